// *** common/acr_pkg.sv ***
// constants, field layouts and carrier types of the converter control block
// assumes a 32-bit apb master on sys_clk and a converter core on the same clock
// ----------------------------------------------------------------
// How it works
// - active bit set at start, cleared at end/abort
// - trigger select: software write or hardware input
// - control bit five enables automatic compare
// - direction bit: greater-equal, otherwise less than
// - result high holds bits nine:eight, zero in 8-bit
// - results load unless compare enabled and false
// - 10-bit high read locks results until low read
// - completions during lock are discarded
// - 8-bit mode has no read lock
// - result low holds low eight bits
// - compare high bits used only in 10-bit
// - compare low bits always compared
// - configuration bit seven selects low power
// - divider field divides by 1, 2, 4, 8
// - configuration bit four selects long sample
// - mode field: 00 8-bit, 10 10-bit
// - clock source: bus, bus/2, alternate, async
// - complete flag set only when compare true
// - first control write aborts; restarts only with software trigger and a channel on
// ----------------------------------------------------------------
package acr_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam int ACR_ADDR_W = 8;
	localparam logic [7:0] OFF_SC1 = 8'h00;
	localparam logic [7:0] OFF_SC2 = 8'h04;
	localparam logic [7:0] OFF_RH = 8'h08;
	localparam logic [7:0] OFF_RL = 8'h0c;
	localparam logic [7:0] OFF_CVH = 8'h10;
	localparam logic [7:0] OFF_CVL = 8'h14;
	localparam logic [7:0] OFF_CFG = 8'h18;

	// ----------------------------------------------------------------
	// field positions and encodings
	// ----------------------------------------------------------------
	localparam int SC1_CONVERSION_COMPLETE_FLAG_BIT = 7;
	localparam int SC2_ACT_BIT = 7;
	localparam int SC2_TRG_BIT = 6;
	localparam int SC2_CFE_BIT = 5;
	localparam int SC2_DIR_BIT = 4;
	localparam logic [4:0] CHAN_OFF = 5'h1f;
	localparam logic [1:0] MODE_8 = 2'h0;
	localparam logic [1:0] MODE_10 = 2'h2;
	localparam logic [1:0] SRC_BUS = 2'h0;
	localparam logic [1:0] SRC_BUS2 = 2'h1;
	localparam logic [1:0] SRC_ALT = 2'h2;
	localparam logic [1:0] SRC_ASYNC = 2'h3;
	localparam logic [1:0] DIV_1 = 2'h0;
	localparam logic [1:0] DIV_2 = 2'h1;
	localparam logic [1:0] DIV_4 = 2'h2;
	localparam logic [1:0] DIV_8 = 2'h3;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [4:0] CHAN_RST = 5'h1f;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [9:0] CV_RST = 10'h000;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic lowPower;
		logic [1:0] clkDiv;
		logic longSample;
		logic [1:0] convMode;
		logic [1:0] clkSrc;
	} acr_cfg_s;

	typedef struct packed {
		logic trgSel;
		logic cmpEn;
		logic cmpDir;
	} acr_ctrl_s;

	typedef struct packed {
		logic start;
		logic abort;
		logic clkEn;
		logic lowPower;
		logic longSample;
		logic mode10;
	} acr_core_s;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} acr_state_e;

endpackage

// *** src/acr_clk_div.sv ***
// conversion clock enable: source select plus power-of-two divider
// assumes alternate and async clocks are slow pins, sampled on sys_clk
`timescale 1ns/100ps
module acr_clk_div
	import acr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic alternateClock,
	input wire logic converterAsyncClock,
	input wire logic [1:0] clkSrc,
	input wire logic [1:0] clkDiv,
	output logic convClkEn
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] altSync_r;
	logic [1:0] asySync_r;
	logic altLast_r;
	logic asyLast_r;
	logic busHalf_r;
	logic srcEn;
	logic [2:0] divCnt_r;

	function automatic logic [2:0] divMask(input logic [1:0] sel);
		case (sel)
			DIV_1: divMask = 3'h0;
			DIV_2: divMask = 3'h1;
			DIV_4: divMask = 3'h3;
			default: divMask = 3'h7;
		endcase
	endfunction

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			altSync_r <= 2'h0;
			asySync_r <= 2'h0;
		end else begin
			altSync_r <= {altSync_r[0], alternateClock};
			asySync_r <= {asySync_r[0], converterAsyncClock};
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			altLast_r <= 1'b0;
			asyLast_r <= 1'b0;
			busHalf_r <= 1'b0;
		end else begin
			altLast_r <= altSync_r[1];
			asyLast_r <= asySync_r[1];
			busHalf_r <= ~busHalf_r;
		end
	end

	// ----------------------------------------------------------------
	// source select and divide
	// ----------------------------------------------------------------
	// source selection
	always_comb begin
		case (clkSrc)
			SRC_BUS: srcEn = 1'b1;
			SRC_BUS2: srcEn = busHalf_r;
			SRC_ALT: srcEn = altSync_r[1] & ~altLast_r;
			default: srcEn = asySync_r[1] & ~asyLast_r;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			divCnt_r <= 3'h0;
			convClkEn <= 1'b0;
		end else begin
			convClkEn <= srcEn & ((divCnt_r & divMask(clkDiv)) == divMask(clkDiv));
			if (srcEn) begin
				divCnt_r <= divCnt_r + 3'h1;
			end
		end
	end

endmodule

// *** src/acr_top.sv ***
// converter control registers, compare, result interlock and triggering
// assumes an apb master on sys_clk and a converter core on sys_clk that
// answers a start pulse with one done pulse carrying a 10-bit sample
`timescale 1ns/100ps
module acr_top
	import acr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ACR_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic hardwareTriggerInput,
	input wire logic alternateClock,
	input wire logic converterAsyncClock,
	input wire logic coreDone,
	input wire logic [9:0] coreData,
	output acr_core_s coreCtl
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [4:0] chanSel_r;
	acr_ctrl_s ctrl_r;
	acr_cfg_s cfg_r;
	logic [9:0] cmpVal_r;
	logic [9:0] result_r;
	logic conversion_complete_flag_r;
	logic lock_r;
	acr_state_e state_r;
	logic [1:0] trgSync_r;
	logic trgLast_r;
	logic startPls_r;
	logic abortPls_r;
	logic convClkEn;
	logic mode10;
	logic setupPh;
	logic accessDone;
	logic wrDone;
	logic rdDone;
	logic mapped;
	logic wrSc1;
	logic hwEdge;
	logic startReq;
	logic doneOk;
	logic cmpTrue;
	logic loadRes;
	logic [7:0] rdByte;

	function automatic logic cmpHit(
		input logic [9:0] res,
		input logic [9:0] cv,
		input logic tenBit,
		input logic dir
	);
		logic ge;
		ge = 1'b0;
		// high compare bits only in 10-bit
		if (tenBit) begin
			ge = res >= cv;
		end else begin
			ge = res[7:0] >= cv[7:0];
		end
		cmpHit = dir ? ge : ~ge;
	endfunction

	function automatic logic isOff(input logic [ACR_ADDR_W-1:0] a, input logic [7:0] off);
		isOff = a == off;
	endfunction

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	// zero wait states; read data is caught in the setup cycle
	assign setupPh = psel & ~penable;
	assign pready = psel & penable;
	assign mapped = isOff(paddr, OFF_SC1) | isOff(paddr, OFF_SC2) | isOff(paddr, OFF_RH) |
		isOff(paddr, OFF_RL) | isOff(paddr, OFF_CVH) | isOff(paddr, OFF_CVL) |
		isOff(paddr, OFF_CFG);
	assign pslverr = pready & ~mapped;
	assign accessDone = pready & mapped;
	assign wrDone = accessDone & pwrite;
	assign rdDone = accessDone & ~pwrite;
	assign wrSc1 = wrDone & isOff(paddr, OFF_SC1);
	assign mode10 = cfg_r.convMode == MODE_10;

	always_comb begin
		rdByte = 8'h00;
		case (paddr)
			OFF_SC1: rdByte = {conversion_complete_flag_r, 2'h0, chanSel_r};
			// reserved low bits read zero
			OFF_SC2: rdByte = {state_r == ST_BUSY, ctrl_r, 4'h0};
			OFF_RH: rdByte = {6'h00, mode10 ? result_r[9:8] : 2'h0};
			OFF_RL: rdByte = result_r[7:0];
			OFF_CVH: rdByte = {6'h00, cmpVal_r[9:8]};
			OFF_CVL: rdByte = cmpVal_r[7:0];
			OFF_CFG: rdByte = cfg_r;
			default: rdByte = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (setupPh) begin
			prdata <= {24'h00_0000, rdByte};
		end
	end

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			chanSel_r <= CHAN_RST;
		end else if (wrSc1) begin
			chanSel_r <= pwdata[4:0];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= '0;
		end else if (wrDone && isOff(paddr, OFF_SC2)) begin
			ctrl_r <= pwdata[SC2_TRG_BIT:SC2_DIR_BIT];
		end
	end

	// low power, long sample, mode kept as written
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cfg_r <= CFG_RST;
		end else if (wrDone && isOff(paddr, OFF_CFG)) begin
			cfg_r <= pwdata[7:0];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cmpVal_r <= CV_RST;
		end else if (wrDone && isOff(paddr, OFF_CVH)) begin
			cmpVal_r[9:8] <= pwdata[1:0];
		end else if (wrDone && isOff(paddr, OFF_CVL)) begin
			cmpVal_r[7:0] <= pwdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// triggering
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			trgSync_r <= 2'h0;
			trgLast_r <= 1'b0;
		end else begin
			trgSync_r <= {trgSync_r[0], hardwareTriggerInput};
			trgLast_r <= trgSync_r[1];
		end
	end

	assign hwEdge = trgSync_r[1] & ~trgLast_r;

	always_comb begin
		startReq = 1'b0;
		if (wrSc1) begin
			startReq = ~ctrl_r.trgSel & (pwdata[4:0] != CHAN_OFF);
		end else if (ctrl_r.trgSel && hwEdge) begin
			startReq = chanSel_r != CHAN_OFF;
		end
	end

	// ----------------------------------------------------------------
	// conversion state
	// ----------------------------------------------------------------
	// a done that arrives with a restart belongs to the aborted run
	assign doneOk = coreDone & (state_r == ST_BUSY) & ~wrSc1;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (startReq) begin
						state_r <= ST_BUSY;
					end
				end
				ST_BUSY: begin
					if (startReq) begin
						state_r <= ST_BUSY;
					end else if (wrSc1 || doneOk) begin
						state_r <= ST_IDLE;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			startPls_r <= 1'b0;
			abortPls_r <= 1'b0;
		end else begin
			startPls_r <= startReq;
			abortPls_r <= wrSc1 & (state_r == ST_BUSY);
		end
	end

	// ----------------------------------------------------------------
	// compare, results and interlock
	// ----------------------------------------------------------------
	// compare enable gates the test
	assign cmpTrue = ~ctrl_r.cmpEn | cmpHit(coreData, cmpVal_r, mode10, ctrl_r.cmpDir);
	assign loadRes = doneOk & cmpTrue & ~lock_r;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			result_r <= 10'h000;
		end else if (loadRes) begin
			result_r <= mode10 ? coreData : {2'h0, coreData[7:0]};
		end
	end

	// no lock in 8-bit
	// mode change drops the lock; old data is stale anyway
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lock_r <= 1'b0;
		end else if (!mode10) begin
			lock_r <= 1'b0;
		end else if (rdDone && isOff(paddr, OFF_RL)) begin
			lock_r <= 1'b0;
		end else if (rdDone && isOff(paddr, OFF_RH)) begin
			lock_r <= 1'b1;
		end
	end

	// flag only on a true compare; set wins over clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			conversion_complete_flag_r <= 1'b0;
		end else if (doneOk && cmpTrue) begin
			conversion_complete_flag_r <= 1'b1;
		end else if (wrSc1 || (rdDone && isOff(paddr, OFF_RL))) begin
			conversion_complete_flag_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// conversion clock and core controls
	// ----------------------------------------------------------------
	acr_clk_div u_div (
		.sys_clk(sys_clk),
		.rst(rst),
		.alternateClock(alternateClock),
		.converterAsyncClock(converterAsyncClock),
		.clkSrc(cfg_r.clkSrc),
		.clkDiv(cfg_r.clkDiv),
		.convClkEn(convClkEn)
	);

	assign coreCtl.start = startPls_r;
	assign coreCtl.abort = abortPls_r;
	assign coreCtl.clkEn = convClkEn;
	assign coreCtl.lowPower = cfg_r.lowPower;
	assign coreCtl.longSample = cfg_r.longSample;
	assign coreCtl.mode10 = mode10;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	active_on_start_a: assert property (startReq |=> state_r == ST_BUSY)
		else $error("active not set after start");
	active_off_done_a: assert property (doneOk && !startReq |=> state_r == ST_IDLE)
		else $error("active not cleared after done");
	sw_start_a: assert property (
		wrSc1 && !ctrl_r.trgSel && pwdata[4:0] != CHAN_OFF |=> startPls_r)
		else $error("software write did not start");
	hw_start_a: assert property (
		ctrl_r.trgSel && !wrSc1 && hwEdge && chanSel_r != CHAN_OFF |=> startPls_r)
		else $error("hardware trigger did not start");
	start_once_a: assert property (startPls_r |=> !startPls_r)
		else $error("start pulse longer than one cycle");
	cmp_block_a: assert property (
		doneOk && ctrl_r.cmpEn && !cmpTrue |=> $stable(result_r) && !$rose(conversion_complete_flag_r))
		else $error("failed compare changed result or flag");
	flag_set_a: assert property (doneOk && cmpTrue |=> conversion_complete_flag_r)
		else $error("flag not set on completion");
	flag_clear_a: assert property (
		rdDone && isOff(paddr, OFF_RL) && !(doneOk && cmpTrue) |=> !conversion_complete_flag_r)
		else $error("flag not cleared by low read");
	lock_set_a: assert property (
		mode10 && rdDone && isOff(paddr, OFF_RH) |=> lock_r)
		else $error("high read did not lock");
	lock_hold_a: assert property (
		lock_r && !(rdDone && isOff(paddr, OFF_RL)) |=> $stable(result_r))
		else $error("result changed while locked");
	high_zero_a: assert property (
		setupPh && isOff(paddr, OFF_RH) && !mode10 |=> prdata[1:0] == 2'h0)
		else $error("upper result bits nonzero in 8-bit");
	load_val_a: assert property (loadRes && mode10 |=> result_r == $past(coreData))
		else $error("result not loaded");
	no_lock8_a: assert property (!mode10 |=> !lock_r)
		else $error("lock held in 8-bit");
	abort_pulse_a: assert property (wrSc1 && state_r == ST_BUSY |=> abortPls_r)
		else $error("restart did not abort");
	act_ro_a: assert property (
		wrDone && isOff(paddr, OFF_SC2) && !startReq && !doneOk |=> $stable(state_r))
		else $error("control write altered active");

	// ----------------------------------------------------------------
	// cover points
	// ----------------------------------------------------------------
	restart_c: cover property (state_r == ST_BUSY && wrSc1 ##1 abortPls_r);
	locked_drop_c: cover property (lock_r && coreDone && state_r == ST_BUSY);
	cmp_pass_c: cover property (doneOk && ctrl_r.cmpEn && cmpTrue);
	hw_trig_c: cover property (ctrl_r.trgSel && hwEdge && chanSel_r != CHAN_OFF);
	mode8_load_c: cover property (loadRes && !mode10);

endmodule

// *** sim/acr_core_model.sv ***
// stand-in for the converter core: one done pulse per start
// assumes start/abort pulses from the control block on sys_clk
`timescale 1ns/100ps
module acr_core_model
	import acr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input acr_core_s coreCtl,
	input wire logic [9:0] sampleVal,
	input wire logic [15:0] delayCyc,
	output logic coreDone,
	output logic [9:0] coreData
);
	// ----------------------------------------------------------------
	// conversion timing
	// ----------------------------------------------------------------
	logic busy_r;
	logic [15:0] cnt_r;

	// data lines toggle outside done so stale values never match
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			busy_r <= 1'b0;
			cnt_r <= 16'h0000;
			coreDone <= 1'b0;
			coreData <= 10'h155;
		end else begin
			coreDone <= 1'b0;
			coreData <= ~coreData;
			if (coreCtl.start) begin
				busy_r <= 1'b1;
				cnt_r <= delayCyc;
			end else if (coreCtl.abort) begin
				busy_r <= 1'b0;
			end else if (busy_r && cnt_r == 16'h0000) begin
				busy_r <= 1'b0;
				coreDone <= 1'b1;
				coreData <= sampleVal;
			end else if (busy_r) begin
				cnt_r <= cnt_r - 16'h0001;
			end
		end
	end
endmodule

// *** sim/adc_compare_result_config_tb.sv ***
// self-checking bench for the converter control block
// assumes acr_top and the core stand-in, all on one 100 MHz clock
`timescale 1ns/100ps
module adc_compare_result_config_tb
	import acr_pkg::*;
;
	logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, lastErr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic hardwareTriggerInput, alternateClock, converterAsyncClock, coreDone;
	logic [9:0] coreData, sampleVal;
	logic [15:0] delayCyc;
	acr_core_s coreCtl;
	int num_errors, cmp_count, seed, tick, startCnt, abortCnt;

	acr_top i_dut(.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .hardwareTriggerInput, .alternateClock, .converterAsyncClock,
		.coreDone, .coreData, .coreCtl);
	acr_core_model i_core(.sys_clk, .rst, .coreCtl, .sampleVal, .delayCyc, .coreDone,
		.coreData);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// slow sources with periods of six and ten cycles
	always @(posedge sys_clk) begin
		tick <= tick + 1;
		if (tick % 3 == 0) alternateClock <= ~alternateClock;
		if (tick % 5 == 0) converterAsyncClock <= ~converterAsyncClock;
		if (coreCtl.start === 1'b1) startCnt <= startCnt + 1;
		if (coreCtl.abort === 1'b1) abortCnt <= abortCnt + 1;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task test_done;
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task bail;
		num_errors++;
		test_done();
	endtask

	task apb(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) bail();
		q = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task waitIdle;
		logic [31:0] q;
		int n;
		n = 0;
		do begin
			apb(1'b0, OFF_SC2, 8'h00, q);
			n++;
		end while (q[SC2_ACT_BIT] !== 1'b0 && n < 200);
		if (q[SC2_ACT_BIT] !== 1'b0) bail();
	endtask

	task waitClk(output int n);
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (coreCtl.clkEn !== 1'b1 && n < 300);
		if (coreCtl.clkEn !== 1'b1) bail();
	endtask

	task conv(input logic [4:0] ch, input logic [9:0] s);
		logic [31:0] q;
		sampleVal <= s;
		apb(1'b1, OFF_SC1, {3'b000, ch}, q);
		apb(1'b0, OFF_SC2, 8'h00, q);
		chk(q[SC2_ACT_BIT], 1'b1);
		waitIdle();
	endtask

	// 8-bit compare ignores the upper bits on both sides
	function logic cmpTrue(logic [9:0] r, logic [9:0] c, logic t, logic d);
		logic [9:0] rr, cc;
		rr = t ? r : {2'b00, r[7:0]};
		cc = t ? c : {2'b00, c[7:0]};
		return d ? (rr >= cc) : (rr < cc);
	endfunction

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] q;
		logic [9:0] cv, s, expRes;
		logic [7:0] cfgv, sc2v;
		logic [4:0] ch;
		logic [1:0] pm;
		logic ok, tb, expValid;
		int i, n, b0, b1;
		{rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
		{hardwareTriggerInput, alternateClock, converterAsyncClock} = 3'b000;
		{sampleVal, delayCyc, lastErr} = {10'h0, 16'h5, 1'b0};
		{num_errors, cmp_count, tick, startCnt, abortCnt} = '0;
		seed = 19;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		for (i = 4; i <= 24; i += 4) begin
			apb(1'b0, i[7:0], 8'h00, q);
			chk(q, 32'h0);
		end
		apb(1'b1, OFF_RL, 8'h5a, q);
		apb(1'b0, OFF_RL, 8'h00, q);
		chk(q, 32'h0);
		apb(1'b0, 8'h1c, 8'h00, q);
		chk(q, 32'h0);
		chk(lastErr, 1'b1);
		expValid = 1'b0;
		pm = MODE_8;
		for (i = 0; i < 24; i++) begin
			cfgv = $random(seed);
			if (cfgv[3:2] != pm) expValid = 1'b0;
			pm = cfgv[3:2];
			tb = (cfgv[3:2] == MODE_10);
			apb(1'b1, OFF_CFG, cfgv, q);
			apb(1'b0, OFF_CFG, 8'h00, q);
			chk(q, cfgv);
			chk({coreCtl.lowPower, coreCtl.longSample, coreCtl.mode10}, {cfgv[7], cfgv[4], tb});
			sc2v = $random(seed) & 8'hb0;
			apb(1'b1, OFF_SC2, sc2v, q);
			apb(1'b0, OFF_SC2, 8'h00, q);
			chk(q, sc2v & 8'h30);
			cv = $random(seed);
			s = (i % 4 == 0) ? cv : $random(seed);
			apb(1'b1, OFF_CVH, {6'h0, cv[9:8]}, q);
			apb(1'b1, OFF_CVL, cv[7:0], q);
			delayCyc <= 16'h5 + ($random(seed) & 16'hf);
			ch = $random(seed) & 5'h0f;
			conv(ch, s);
			ok = !sc2v[5] || cmpTrue(s, cv, tb, sc2v[4]);
			if (ok) begin
				expRes = tb ? s : {2'b00, s[7:0]};
				expValid = 1'b1;
			end
			apb(1'b0, OFF_SC1, 8'h00, q);
			chk(q, {24'h0, ok, 2'b00, ch});
			apb(1'b0, OFF_RH, 8'h00, q);
			if (expValid) chk(q, {30'h0, expRes[9:8]});
			apb(1'b0, OFF_RL, 8'h00, q);
			if (expValid) chk(q, {24'h0, expRes[7:0]});
		end
		// high read then a second conversion before the low read
		for (i = 0; i < 2; i++) begin
			apb(1'b1, OFF_CFG, {4'h0, i ? MODE_10 : MODE_8, 2'b00}, q);
			apb(1'b1, OFF_SC2, 8'h00, q);
			conv(5'h01, 10'h2a5);
			apb(1'b0, OFF_RH, 8'h00, q);
			conv(5'h01, 10'h15a);
			apb(1'b0, OFF_RL, 8'h00, q);
			chk(q, i ? 32'ha5 : 32'h5a);
			conv(5'h01, 10'h0c3);
			apb(1'b0, OFF_RL, 8'h00, q);
			chk(q, 32'hc3);
		end
		delayCyc <= 16'd4000;
		n = startCnt;
		b0 = abortCnt;
		apb(1'b1, OFF_SC1, 8'h03, q);
		apb(1'b1, OFF_SC1, 8'h04, q);
		apb(1'b1, OFF_SC2, 8'h00, q);
		apb(1'b0, OFF_SC2, 8'h00, q);
		chk(q, 32'h80);
		chk(startCnt - n, 2);
		chk(abortCnt - b0, 1);
		// third interval only: a mid-count switch may stretch the first two
		for (i = 0; i < 16; i++) begin
			apb(1'b1, OFF_CFG, {1'b0, i[3:2], 3'b000, i[1:0]}, q);
			repeat (3) waitClk(n);
			b1 = (i[1:0] == SRC_BUS) ? 1 : (i[1:0] == SRC_BUS2) ? 2 : (i[1:0] == SRC_ALT) ? 6 : 10;
			chk(n, b1 << i[3:2]);
		end
		n = abortCnt;
		apb(1'b1, OFF_SC1, {3'b000, CHAN_OFF}, q);
		apb(1'b0, OFF_SC2, 8'h00, q);
		chk(q, 32'h0);
		chk(abortCnt - n, 1);
		delayCyc <= 16'd8;
		for (i = 0; i < 2; i++) begin
			apb(1'b1, OFF_SC1, 8'h02, q);
			waitIdle();
			apb(1'b1, OFF_SC2, {1'b0, i[0], 6'h00}, q);
			sampleVal <= 10'h3c7 ^ i[9:0];
			n = startCnt;
			@(posedge sys_clk);
			hardwareTriggerInput <= 1'b1;
			repeat (8) @(posedge sys_clk);
			hardwareTriggerInput <= 1'b0;
			chk(startCnt - n, i);
			waitIdle();
			apb(1'b0, OFF_RL, 8'h00, q);
			chk(q, i ? 32'hc6 : 32'hc3);
		end
		test_done();
	end
endmodule
